// file: hsrp_chk.sv
// Purpose: Link-level assertions for the host serial register port.
// Assumes: Both ends run from the same CLK, which samples the link.
// Notes: Watches the link where both ends are design modules.
`timescale 1ns/1ps
module hsrp_chk (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic sclk,
   input wire logic host_select_n,
   input wire logic host_write_line,
   input wire logic host_write_oe,
   input wire logic read_line,
   input wire logic read_oe,
   input wire logic host_write_bus,
   input wire logic read_bus
);
   logic sclk_ff;
   logic [4:0] rise_cnt_ff;
   logic [4:0] nxt_rise_cnt;

   // Rising serial clock edges seen in the current frame
   assign nxt_rise_cnt = host_select_n ? 5'h00 : rise_cnt_ff + {4'h0, sclk & ~sclk_ff};

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_ff <= 1'b0;
         rise_cnt_ff <= 5'h00;
      end else begin
         sclk_ff <= sclk;
         rise_cnt_ff <= nxt_rise_cnt;
      end
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);

   a_no_line_clash: assert property (!(host_write_oe && read_oe))
      else $error("write and read lines driven together");
   a_read_idle_deselect: assert property (host_select_n [*5] |-> !read_oe && read_bus)
      else $error("read line driven while deselected");
   a_read_in_frame: assert property ($rose(read_oe) |-> !host_select_n)
      else $error("read line enabled outside a frame");
   a_sclk_idle_deselect: assert property (host_select_n |-> !sclk)
      else $error("serial clock moves while deselected");
   a_read_held_high: assert property ((read_oe && $past(read_oe) && sclk && $past(sclk))
      |-> $stable(read_line))
      else $error("read bit changed while serial clock high");
   a_write_held_high: assert property ((host_write_oe && sclk && $past(sclk))
      |-> $stable(host_write_line) && $stable(host_write_bus))
      else $error("write bit changed while serial clock high");
   a_setup_low: assert property ($fell(host_select_n) |-> !sclk [*4])
      else $error("serial clock started too soon after select");
   a_select_held: assert property ($fell(host_select_n) |=> !host_select_n [*8])
      else $error("select released early in a frame");
   a_high_phase: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("serial clock high phase not four cycles");
   a_low_phase: assert property (($fell(sclk) && !host_select_n) |-> !sclk [*4])
      else $error("serial clock low phase too short");
   a_bit_count: assert property ($rose(host_select_n)
      |-> rise_cnt_ff inside {5'h08, 5'h10, 5'h18})
      else $error("frame did not carry whole bytes");

   c_read_frame: cover property ($rose(read_oe));
   c_long_frame: cover property ($rose(host_select_n) && rise_cnt_ff == 5'h18);
   c_cmd_frame: cover property ($rose(host_select_n) && rise_cnt_ff == 5'h08);
endmodule

// file: hsrp_device.sv
// Purpose: Device end of the host serial register port.
// Assumes: Link pins are asynchronous to CLK and are oversampled.
// Notes: Serial clock must be slow enough for four CLK samples per phase.
`timescale 1ns/1ps
module hsrp_device
   import hsrp_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   hsrp_if.dev_mp LINK,
   output logic CMD_VALID,
   output logic WR_VALID,
   output logic [AC_W-1:0] WR_ADDR,
   output logic [DATA_W-1:0] WR_DATA,
   output logic RD_REQ,
   output logic [AC_W-1:0] RD_ADDR,
   input wire logic [DATA_W-1:0] RD_DATA
);
   logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
   logic sel_s1_ff, sel_s2_ff;
   logic wr_s1_ff, wr_s2_ff;
   logic [2:0] bit_cnt_ff;
   logic [1:0] byte_cnt_ff;
   logic [1:0] len_ff;
   logic rd_ff;
   logic [DATA_W-1:0] rx_sh_ff;
   logic [DATA_W-1:0] tx_sh_ff;
   logic [RD_LAT-1:0] rd_pend_ff;
   logic miso_ff;
   logic cmd_ff, wr_ff, rdq_ff;
   logic [AC_W-1:0] addr_ff;
   logic [DATA_W-1:0] wdata_ff;
   logic oe_ff;

   // Every edge is taken from the second sync stage onward
   // Three CLK of lag per edge limit how fast the serial clock may run
   wire selected = ~sel_s2_ff;
   wire rise = selected & sclk_s2_ff & ~sclk_s3_ff;
   wire fall = selected & ~sclk_s2_ff & sclk_s3_ff;
   wire byte_end = rise & (bit_cnt_ff == 3'h7);
   wire [DATA_W-1:0] rx_next = {rx_sh_ff[DATA_W-2:0], wr_s2_ff};
   wire [AC_W-1:0] ac_next = rx_next[AC_W-1:0];
   wire [1:0] ac_len = hsrp_ac_len(ac_next);
   wire ac_is_rd = ac_next[AC_RD_POS];
   wire ac_done = byte_end & (byte_cnt_ff == LEN_NONE);
   wire data_done = byte_end & (byte_cnt_ff != LEN_NONE) & (byte_cnt_ff == len_ff);
   wire rd_phase = rd_ff & (byte_cnt_ff != LEN_NONE);
   wire [DATA_W-1:0] rd_align = (len_ff == LEN_ONE) ?
                                {RD_DATA[BYTE_W-1:0], {BYTE_W{1'b0}}} : RD_DATA;
   wire [DATA_W-1:0] wr_align = (len_ff == LEN_ONE) ?
                                {{BYTE_W{1'b0}}, rx_next[BYTE_W-1:0]} : rx_next;

   // Serial clock keeps a third stage so both of its edges can be seen
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_s1_ff <= 1'b0;
         sclk_s2_ff <= 1'b0;
         sclk_s3_ff <= 1'b0;
      end else begin
         sclk_s1_ff <= LINK.sclk;
         sclk_s2_ff <= sclk_s1_ff;
         sclk_s3_ff <= sclk_s2_ff;
      end
   end

   // Select rests high, so leaving reset never opens a frame
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sel_s1_ff <= 1'b1;
         sel_s2_ff <= 1'b1;
      end else begin
         sel_s1_ff <= LINK.host_select_n;
         sel_s2_ff <= sel_s1_ff;
      end
   end

   // Write line rests at its pull-up level
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wr_s1_ff <= 1'b1;
         wr_s2_ff <= 1'b1;
      end else begin
         wr_s1_ff <= LINK.host_write_bus;
         wr_s2_ff <= wr_s1_ff;
      end
   end

   // Bit and byte position within the transaction
   // Byte count saturates, so bytes past the decoded length are ignored
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         bit_cnt_ff <= 3'h0;
         byte_cnt_ff <= LEN_NONE;
      end else if (!selected) begin
         bit_cnt_ff <= 3'h0;
         byte_cnt_ff <= LEN_NONE;
      end else if (rise) begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         if (byte_end && byte_cnt_ff != LEN_OVER) begin
            byte_cnt_ff <= byte_cnt_ff + 2'h1;
         end
      end
   end

   // Address/command byte decode, held for the rest of the transaction
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         len_ff <= LEN_NONE;
         rd_ff <= 1'b0;
         addr_ff <= '0;
      end else if (!selected) begin
         rd_ff <= 1'b0;
      end else if (ac_done) begin
         len_ff <= ac_len;
         rd_ff <= ac_is_rd & (ac_len != LEN_NONE);
         addr_ff <= ac_next;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_sh_ff <= '0;
      end else if (rise) begin
         rx_sh_ff <= rx_next;
      end
   end

   // Strobes to the register side; extra bits past the length are dropped
   // A frame cut short never reaches data_done, so it writes nothing
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmd_ff <= 1'b0;
         wr_ff <= 1'b0;
         rdq_ff <= 1'b0;
         wdata_ff <= '0;
      end else begin
         cmd_ff <= ac_done & (ac_len == LEN_NONE);
         wr_ff <= data_done & ~rd_ff;
         rdq_ff <= ac_done & ac_is_rd & (ac_len != LEN_NONE);
         if (data_done && !rd_ff) begin
            wdata_ff <= wr_align;
         end
      end
   end

   // Read word fetched a fixed latency after the request pulse
   // Fixed latency saves a handshake; the register side must answer in time
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rd_pend_ff <= '0;
      end else begin
         rd_pend_ff <= {rd_pend_ff[RD_LAT-2:0], rdq_ff};
      end
   end

   // Next bit goes out on the falling edge so it is settled for the high phase
   // Bits past the word are zeros and fall outside the frame's length
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_sh_ff <= '0;
         miso_ff <= 1'b0;
      end else if (!selected) begin
         miso_ff <= 1'b0;
      end else if (rd_pend_ff[RD_LAT-1]) begin
         tx_sh_ff <= rd_align;
      end else if (fall && rd_phase) begin
         miso_ff <= tx_sh_ff[DATA_W-1];
         tx_sh_ff <= {tx_sh_ff[DATA_W-2:0], 1'b0};
      end
   end

   // Read line is taken only at the first fall of the data phase: the host
   // still drives its line through the high phase of the last address bit
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         oe_ff <= 1'b0;
      end else if (!selected) begin
         oe_ff <= 1'b0;
      end else if (fall && rd_phase) begin
         oe_ff <= 1'b1;
      end
   end

   // One address register serves both directions
   assign LINK.read_line = miso_ff;
   assign LINK.read_oe = selected & oe_ff;
   assign CMD_VALID = cmd_ff;
   assign WR_VALID = wr_ff;
   assign WR_ADDR = addr_ff;
   assign WR_DATA = wdata_ff;
   assign RD_REQ = rdq_ff;
   assign RD_ADDR = addr_ff;
endmodule

// file: hsrp_host.sv
// Purpose: Host end of the serial register port, with a request FIFO.
// Assumes: Requests carry address byte and a right-aligned data word.
// Notes: Serial clock idles low and is divided from CLK.
`timescale 1ns/1ps
module hsrp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [WIDTH-1:0] IN_DATA,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [WIDTH-1:0] OUT_DATA
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_ff, rd_ptr_ff;

   wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
   wire empty = (wr_ptr_ff == rd_ptr_ff);
   wire push = IN_VALID & ~full;
   wire pop = OUT_READY & ~empty;

   always_ff @(posedge CLK) begin
      if (push) begin
         mem[wr_ptr_ff[AW-1:0]] <= IN_DATA;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
         rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
      end
   end

   assign IN_READY = ~full;
   assign OUT_VALID = ~empty;
   assign OUT_DATA = mem[rd_ptr_ff[AW-1:0]];
endmodule

module hsrp_host
   import hsrp_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   hsrp_if.host_mp LINK,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic [AC_W-1:0] REQ_ADDR,
   input wire logic [DATA_W-1:0] REQ_DATA,
   output logic RSP_VALID,
   output logic [DATA_W-1:0] RSP_DATA,
   output logic BUSY
);
   hsrp_state_e state_ff, nxt_state;
   logic [2:0] div_ff;
   logic sclk_ff, sel_n_ff, rd_ff;
   logic [4:0] bit_ff;
   logic [4:0] last_ff;
   logic [REQ_W-1:0] tx_sh_ff;
   logic [DATA_W-1:0] rx_sh_ff;
   logic [1:0] len_ff;
   logic rsp_ff;
   logic [DATA_W-1:0] rsp_data_ff;
   logic miso_s1_ff, miso_s2_ff;
   logic q_valid;
   logic [REQ_W-1:0] q_data;

   wire idle = (state_ff == HSRP_IDLE);
   wire tick = (div_ff == SCLK_HALF_LAST);
   wire take = idle & q_valid;
   wire [AC_W-1:0] q_ac = q_data[REQ_W-1:DATA_W];
   wire [1:0] q_len = hsrp_ac_len(q_ac);
   wire [DATA_W-1:0] q_word = (q_len == LEN_ONE) ?
                              {q_data[BYTE_W-1:0], {BYTE_W{1'b0}}} : q_data[DATA_W-1:0];
   wire [4:0] q_last = 5'(BYTE_W * (32'(q_len) + 1) - 1);
   wire fall_now = (state_ff == HSRP_SHIFT) & tick & sclk_ff;
   wire in_ac = (bit_ff < 5'(BYTE_W));

   hsrp_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_req_fifo (
      .CLK(CLK),
      .RSTN(RSTN),
      .IN_VALID(REQ_VALID),
      .IN_READY(REQ_READY),
      .IN_DATA({REQ_ADDR, REQ_DATA}),
      .OUT_VALID(q_valid),
      .OUT_READY(idle),
      .OUT_DATA(q_data)
   );

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         HSRP_IDLE: if (q_valid) nxt_state = HSRP_SETUP;
         HSRP_SETUP: if (tick) nxt_state = HSRP_SHIFT;
         HSRP_SHIFT: if (fall_now && bit_ff == last_ff) nxt_state = HSRP_HOLD;
         HSRP_HOLD: if (tick) nxt_state = HSRP_IDLE;
         default: nxt_state = HSRP_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_ff <= HSRP_IDLE;
         div_ff <= 3'h0;
         miso_s1_ff <= 1'b1;
         miso_s2_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         div_ff <= (idle || tick) ? 3'h0 : div_ff + 3'h1;
         miso_s1_ff <= LINK.read_bus;
         miso_s2_ff <= miso_s1_ff;
      end
   end

   // Select stays low from setup through hold
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sel_n_ff <= 1'b1;
         sclk_ff <= 1'b0;
         bit_ff <= 5'h0;
         last_ff <= 5'h0;
         len_ff <= LEN_NONE;
         rd_ff <= 1'b0;
         tx_sh_ff <= '0;
         rx_sh_ff <= '0;
      end else if (take) begin
         sel_n_ff <= 1'b0;
         bit_ff <= 5'h0;
         last_ff <= q_last;
         len_ff <= q_len;
         rd_ff <= q_ac[AC_RD_POS] & (q_len != LEN_NONE);
         tx_sh_ff <= {q_ac, q_word};
      end else if (state_ff == HSRP_SHIFT && tick) begin
         sclk_ff <= ~sclk_ff;
         if (sclk_ff) begin
            // Late in the high phase the read bit has settled
            rx_sh_ff <= {rx_sh_ff[DATA_W-2:0], miso_s2_ff};
            tx_sh_ff <= {tx_sh_ff[REQ_W-2:0], 1'b0};
            bit_ff <= bit_ff + 5'h1;
         end
      end else if (state_ff == HSRP_HOLD && tick) begin
         sel_n_ff <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rsp_ff <= 1'b0;
         rsp_data_ff <= '0;
      end else begin
         rsp_ff <= (state_ff == HSRP_HOLD) & tick & rd_ff;
         if (state_ff == HSRP_HOLD && tick && rd_ff) begin
            rsp_data_ff <= (len_ff == LEN_ONE) ?
                           {{BYTE_W{1'b0}}, rx_sh_ff[BYTE_W-1:0]} : rx_sh_ff;
         end
      end
   end

   assign LINK.sclk = sclk_ff;
   assign LINK.host_select_n = sel_n_ff;
   assign LINK.host_write_line = tx_sh_ff[REQ_W-1];
   // Write line released while the device returns read data, and during setup,
   // while the device may still drive the read line of the previous frame
   assign LINK.host_write_oe = ~sel_n_ff & (state_ff != HSRP_SETUP) & ~(rd_ff & ~in_ac);
   assign RSP_VALID = rsp_ff;
   assign RSP_DATA = rsp_data_ff;
   assign BUSY = ~idle;
endmodule

// file: hsrp_if.sv
// Purpose: Four-wire link between the host end and the device end.
// Assumes: Undriven lines rest high, as with a pull-up.
// Notes: The write and read drivers give value and enable; those wire levels are resolved here.
`timescale 1ns/1ps
interface hsrp_if;
   logic sclk;
   logic host_select_n;
   logic host_write_line;
   logic host_write_oe;
   logic read_line;
   logic read_oe;
   wire host_write_bus;
   wire read_bus;

   assign host_write_bus = host_write_oe ? host_write_line : 1'b1;
   assign read_bus = read_oe ? read_line : 1'b1;

   modport host_mp (
      output sclk,
      output host_select_n,
      output host_write_line,
      output host_write_oe,
      input read_bus
   );

   modport dev_mp (
      input sclk,
      input host_select_n,
      input host_write_bus,
      output read_line,
      output read_oe
   );
endinterface

// file: hsrp_pkg.sv
// Purpose: Shared constants for the host serial register port, both ends.
// Assumes: 50 MHz system clock on each end; host makes the serial clock.
// Notes: Address/command byte decodes to a data byte count and direction.
package hsrp_pkg;
   localparam int AC_W = 8;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int REQ_W = AC_W + DATA_W;
   localparam int AC_RD_POS = 7;
   localparam int AC_LONG_POS = 6;
   localparam logic [7:0] AC_CMD_LIMIT = 8'h10;
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCLK_PERIOD_NS = 160;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [2:0] SCLK_HALF_LAST = 3'(SCLK_HALF_CYC - 1);
   localparam int RD_LAT = 2;
   localparam int FIFO_DEPTH = 8;
   localparam logic [1:0] LEN_NONE = 2'h0;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_OVER = 2'h3;

   typedef enum logic [3:0] {
      HSRP_IDLE = 4'b0001,
      HSRP_SETUP = 4'b0010,
      HSRP_SHIFT = 4'b0100,
      HSRP_HOLD = 4'b1000
   } hsrp_state_e;

   // Data bytes that follow a given address/command byte
   function automatic logic [1:0] hsrp_ac_len(input logic [7:0] ac);
      logic [1:0] len;
      len = LEN_NONE;
      if (ac >= AC_CMD_LIMIT) begin
         len = ac[AC_LONG_POS] ? LEN_TWO : LEN_ONE;
      end
      return len;
   endfunction
endpackage

// file: tb_host_serial_register_port.sv
// Purpose: Self-checking bench for both ends of the host serial register port.
// Assumes: Second link is driven by the bench to play an awkward host.
// Notes: Device read data on the first link is a fixed function of the address.
`timescale 1ns/1ps
module tb_host_serial_register_port import hsrp_pkg::*;;
   logic CLK, RSTN, req_valid, req_ready, rsp_valid, busy;
   logic cmd_v, wr_v, rd_req, cmd_v2, wr_v2, rd_req2, sclk_d;
   logic [7:0] req_addr, wr_addr, rd_addr, wr_addr2, rd_addr2;
   logic [15:0] req_data, rsp_data, rd_data, wr_data, wr_data2, r;
   logic [26:0] ev1[$], ev2[$];
   logic [15:0] rsp_q[$];
   logic [28:0] frm_q[$];
   logic [23:0] wsh;
   logic [4:0] nbit;
   logic [7:0] tbl [12] = '{8'h0f, 8'h10, 8'h3f, 8'h40, 8'h7f, 8'h80, 8'hbf, 8'hc0, 8'hff,
      8'h05, 8'h5a, 8'h9c};
   logic [26:0] exp2 [5] = '{{3'b010, 8'h4c, 16'h1234}, {3'b010, 8'h1d, 16'h00e7},
      {3'b001, 8'hc1, 16'h0000}, {3'b001, 8'h81, 16'h0000}, {3'b100, 8'h0a, 16'h0000}};
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int j;
   hsrp_if lk1();
   hsrp_if lk2();

   hsrp_host u_hsrp_host (.CLK(CLK), .RSTN(RSTN), .LINK(lk1.host_mp), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .RSP_VALID(rsp_valid),
      .RSP_DATA(rsp_data), .BUSY(busy));
   hsrp_device u_hsrp_device (.CLK(CLK), .RSTN(RSTN), .LINK(lk1.dev_mp), .CMD_VALID(cmd_v),
      .WR_VALID(wr_v), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_REQ(rd_req),
      .RD_ADDR(rd_addr), .RD_DATA(rd_data));
   hsrp_device u_hsrp_device_2 (.CLK(CLK), .RSTN(RSTN), .LINK(lk2.dev_mp), .CMD_VALID(cmd_v2),
      .WR_VALID(wr_v2), .WR_ADDR(wr_addr2), .WR_DATA(wr_data2), .RD_REQ(rd_req2),
      .RD_ADDR(rd_addr2), .RD_DATA(16'h5a3c));
   hsrp_chk u_hsrp_chk (.CLK(CLK), .RSTN(RSTN), .sclk(lk1.sclk),
      .host_select_n(lk1.host_select_n), .host_write_line(lk1.host_write_line),
      .host_write_oe(lk1.host_write_oe), .read_line(lk1.read_line), .read_oe(lk1.read_oe),
      .host_write_bus(lk1.host_write_bus), .read_bus(lk1.read_bus));

   function automatic logic [26:0] pk(input logic c, w, rq, input logic [7:0] a,
      input logic [15:0] d);
      return {c, w, rq, a, w ? d : 16'h0000};
   endfunction

   function automatic logic [26:0] exp_ev(input logic [7:0] a);
      if (a < AC_CMD_LIMIT) return {3'b100, a, 16'h0000};
      if (a[7]) return {3'b001, a, 16'h0000};
      return {3'b010, a, a[6] ? {a, ~a} : {8'h00, ~a}};
   endfunction

   // Undriven write line reads as 1 during read data
   function automatic logic [28:0] exp_fr(input logic [7:0] a);
      if (a < AC_CMD_LIMIT) return {5'h08, 16'h0000, a};
      if (a[7]) return a[6] ? {5'h18, a, 16'hffff} : {5'h10, 8'h00, a, 8'hff};
      return a[6] ? {5'h18, a, a, ~a} : {5'h10, 8'h00, a, ~a};
   endfunction

   task automatic check(input string what, input logic [28:0] seen, input logic [28:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Valid stays up between pushes; caller lowers it
   task automatic push(input logic [7:0] a);
      req_addr <= a;
      req_data <= {a, ~a};
      req_valid <= 1'b1;
      @(posedge CLK);
      while (req_ready !== 1'b1) @(posedge CLK);
   endtask

   // Bit changes after each fall; write line let go early on a read
   task automatic bb_byte(input logic [7:0] b, input logic rel, output logic [7:0] t);
      for (int i = 7; i >= 0; i--) begin
         lk2.sclk <= 1'b0;
         lk2.host_write_line <= b[i];
         repeat (4) @(posedge CLK);
         lk2.sclk <= 1'b1;
         @(posedge CLK);
         if (rel && i == 0) lk2.host_write_oe <= 1'b0;
         repeat (3) @(posedge CLK);
         t[i] = lk2.read_bus;
      end
   endtask

   task automatic bb_frame(input logic [7:0] a, input logic [15:0] d, input int nb,
      output logic [15:0] rv);
      logic [7:0] t;
      rv = 16'h0000;
      lk2.host_select_n <= 1'b0;
      lk2.host_write_oe <= 1'b1;
      repeat (4) @(posedge CLK);
      bb_byte(a, a[7], t);
      for (int k = 0; k < nb; k++) begin
         repeat (12) @(posedge CLK);
         bb_byte(d[8*(nb-1-k) +: 8], 1'b0, t);
         rv = {rv[7:0], t};
      end
      repeat (4) @(posedge CLK);
      lk2.host_select_n <= 1'b1;
      lk2.host_write_oe <= 1'b0;
      repeat (8) @(posedge CLK);
   endtask

   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      if (rd_req) rd_data <= {~rd_addr, rd_addr};
      if (cmd_v | wr_v | rd_req) ev1.push_back(pk(cmd_v, wr_v, rd_req,
         rd_req ? rd_addr : wr_addr, wr_data));
      if (cmd_v2 | wr_v2 | rd_req2) ev2.push_back(pk(cmd_v2, wr_v2, rd_req2,
         rd_req2 ? rd_addr2 : wr_addr2, wr_data2));
      if (rsp_valid) rsp_q.push_back(rsp_data);
      sclk_d <= lk1.sclk;
      if (lk1.host_select_n) begin
         if (nbit != 5'h00) frm_q.push_back({nbit, wsh});
         nbit <= 5'h00;
         wsh <= 24'h000000;
      end else if (lk1.sclk && !sclk_d) begin
         wsh <= {wsh[22:0], lk1.host_write_bus};
         nbit <= nbit + 5'h01;
      end
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         errors++;
         conclude();
      end
   end

   initial begin
      RSTN = 1'b0;
      req_valid = 1'b0;
      req_addr = 8'h00;
      req_data = 16'h0000;
      rd_data = 16'h0000;
      nbit = 5'h00;
      wsh = 24'h000000;
      sclk_d = 1'b0;
      lk2.sclk = 1'b1;
      lk2.host_select_n = 1'b1;
      lk2.host_write_line = 1'b1;
      lk2.host_write_oe = 1'b0;
      repeat (12) @(posedge CLK);
      RSTN <= 1'b1;
      @(posedge CLK);
      foreach (tbl[i]) begin
         push(tbl[i]);
         if (i == 8) begin
            req_valid <= 1'b0;
            @(posedge CLK);
            check("fifo_ready", {28'h0000000, req_ready}, 29'h0);
         end
      end
      req_valid <= 1'b0;
      while (ev1.size() < 12 || rsp_q.size() < 5 || frm_q.size() < 12 || busy) @(posedge CLK);
      j = 0;
      foreach (tbl[i]) begin
         check("event", ev1[i], exp_ev(tbl[i]));
         check("frame", frm_q[i], exp_fr(tbl[i]));
         if (tbl[i] >= AC_CMD_LIMIT && tbl[i][7]) begin
            check("response", rsp_q[j], tbl[i][6] ? {~tbl[i], tbl[i]} : {8'h00, tbl[i]});
            j++;
         end
      end
      bb_frame(8'h4c, 16'h1234, 1, r);
      bb_frame(8'h4c, 16'h1234, 2, r);
      bb_frame(8'h1d, 16'h00e7, 1, r);
      bb_frame(8'hc1, 16'h0000, 2, r);
      check("read_word", r, 16'h5a3c);
      bb_frame(8'h81, 16'h0000, 1, r);
      check("read_byte", r, 16'h003c);
      bb_frame(8'h0a, 16'h0000, 0, r);
      check("events2", 29'(ev2.size()), 29'h5);
      foreach (exp2[i]) check("event2", ev2[i], exp2[i]);
      conclude();
   end
endmodule
